// File: lmd_pkg.sv
// Operation
// - shift-by-multiplicand load shifts data word by multiplicand low four bits into accumulator
// - accumulator load shifts zero-fill low bits, sign-extend high bits when sign_extend_mode is one
// - long-immediate load puts 16-bit constant, optionally shifted, into accumulator
// - aux register load takes data word, 8-bit short or 16-bit long immediate
// - short aux load writes 8-bit constant as positive value
// - aux pointer load writes 3-bit constant selecting one of eight aux registers
// - page load takes nine data bits or 9-bit immediate; address is page plus 7-bit offset
// - pages eight up external, four to seven blocks zero/one, block two top 32 of page zero
// - high product load writes upper 16 product bits, lower bits unchanged
// - status loads write status word zero, one, or the indexed word
// - load-and-add loads multiplicand and adds mode-shifted product to accumulator
// - load-add-move also copies data word upward; both addresses in on-chip RAM
// - load-and-take-product loads multiplicand and copies product into accumulator
// - load-and-subtract loads multiplicand and subtracts mode-shifted product from accumulator
// - multiply-accumulate multiplies data by program word and adds shifted previous product
// - multiply-accumulate-move copies data upward only from RAM blocks zero, one or two
// - aux modify updates aux pointer as specified; no-operation in indirect mode
package lmd_pkg;
    localparam int DW     = 16;
    localparam int RAM_AW = 10;
    localparam int PAW    = 13;

    localparam logic [12:0] OFF_CMD  = 13'h0000;
    localparam logic [12:0] OFF_IMM  = 13'h0004;
    localparam logic [12:0] OFF_PROG = 13'h0008;
    localparam logic [12:0] OFF_EXT  = 13'h000c;
    localparam logic [12:0] OFF_ACC  = 13'h0010;
    localparam logic [12:0] OFF_PREG = 13'h0014;
    localparam logic [12:0] OFF_TREG = 13'h0018;
    localparam logic [12:0] OFF_ST0  = 13'h001c;
    localparam logic [12:0] OFF_ST1  = 13'h0020;
    localparam logic [12:0] OFF_ADDR = 13'h0024;
    localparam logic [12:0] OFF_AR   = 13'h0040;
    localparam logic [12:0] OFF_RAM  = 13'h1000;

    localparam int ST0_ARP_LSB = 13;
    localparam int ST1_SXM_BIT = 10;
    localparam int ST1_PM_LSB  = 0;
    localparam logic [15:0] ST0_RST = 16'h0000;
    localparam logic [15:0] ST1_RST = 16'h0400;

    localparam logic [8:0] PAGE_EXT_MIN = 9'h008;
    localparam logic [8:0] PAGE_B0_LO   = 9'h004;
    localparam logic [8:0] PAGE_B1_LO   = 9'h006;
    localparam logic [8:0] PAGE_B2      = 9'h000;
    localparam logic [6:0] B2_OFS_MIN   = 7'h60;
    localparam logic [1:0] IDX_B0       = 2'h0;
    localparam logic [1:0] IDX_B1       = 2'h1;
    localparam logic [1:0] IDX_B2       = 2'h2;

    typedef enum logic [4:0] {
        OP_NOP, OP_LOAD_ACC_TSHIFT, OP_LOAD_ACC_LONG_IMM, OP_LAR_DATA, OP_LAR_SHORT, OP_LAR_LONG,
        OP_LOAD_AUX_POINTER, OP_LDP, OP_LOAD_PAGE_SHORT, OP_LPH, OP_LST0, OP_LOAD_STATUS_ONE, OP_LSTN,
        OP_LT, OP_LTA, OP_LTD, OP_LTP, OP_LTS, OP_MAC, OP_MUL_ACC_MOVE, OP_MAR
    } lmd_op_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FETCH = 2'b01,
        ST_EXEC  = 2'b11
    } lmd_state_t;

    typedef enum logic [2:0] {
        RG_EXT, RG_OTHER, RG_B0, RG_B1, RG_B2
    } lmd_region_t;

    typedef struct packed {
        logic [11:0] rsvd;
        logic [6:0]  offset;
        logic [3:0]  shift;
        logic [2:0]  sel;
        logic        indirect;
        lmd_op_t     op;
    } lmd_cmd_t;

    function automatic lmd_region_t region_of(logic [15:0] a);
        if (a[15:7] >= PAGE_EXT_MIN)
            return RG_EXT;
        else if (a[15:7] >= PAGE_B1_LO)
            return RG_B1;
        else if (a[15:7] >= PAGE_B0_LO)
            return RG_B0;
        else if (a[15:7] == PAGE_B2 && a[6:0] >= B2_OFS_MIN)
            return RG_B2;
        else
            return RG_OTHER;
    endfunction

    function automatic logic is_onchip(lmd_region_t r);
        return r == RG_B0 || r == RG_B1 || r == RG_B2;
    endfunction

    function automatic logic [9:0] ram_index(logic [15:0] a);
        unique case (region_of(a))
            RG_B1:   return {IDX_B1, a[7:0]};
            RG_B2:   return {IDX_B2, 3'h0, a[4:0]};
            default: return {IDX_B0, a[7:0]};
        endcase
    endfunction

    // product shift mode: none, left 1, left 4, arithmetic right 6
    function automatic logic [31:0] pshift(logic [31:0] p, logic [1:0] pm);
        unique case (pm)
            2'h0: return p;
            2'h1: return {p[30:0], 1'b0};
            2'h2: return {p[27:0], 4'h0};
            2'h3: return {{6{p[31]}}, p[31:6]};
        endcase
    endfunction
endpackage

// File: lmd_shifter.sv
`timescale 1ns/100ps
module lmd_shifter (
    // operand
    input  wire logic [15:0] value,
    input  wire logic [3:0]  amount,
    input  wire logic        sign_extend_mode,
    // result
    output logic      [31:0] result
);
    logic [31:0] widened;

    always_comb
    begin
        widened = sign_extend_mode ? {{16{value[15]}}, value}
                                   : {16'h0000, value};
        result  = widened << amount;
    end
endmodule

// File: lmd_dram.sv
`timescale 1ns/100ps
module lmd_dram #(
    parameter int DW = 16,
    parameter int AW = 10
) (
    // clock
    input  wire logic          pclk,
    // port
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic      [DW-1:0] q
);
    logic [DW-1:0] mem [2**AW];

    if (DW < 1 || AW < 1)
        $error("lmd_dram: bad geometry");

    // no reset on the array, so it maps to a plain RAM macro
    always_ff @(posedge pclk)
    begin
        if (we)
            mem[addr] <= wdata;
        q <= mem[addr];
    end
endmodule

// File: lmd_datapath.sv
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/100ps
module lmd_datapath (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [12:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);
    lmd_pkg::lmd_state_t  state_r;
    lmd_pkg::lmd_cmd_t    cmd_r;
    lmd_pkg::lmd_region_t region_r;
    logic [15:0] imm_r;
    logic [15:0] prog_r;
    logic [15:0] ext_r;
    logic [31:0] acc_r;
    logic [31:0] preg_r;
    logic [15:0] treg_r;
    logic [15:0] st0_r;
    logic [15:0] st1_r;
    logic [15:0] addr_r;
    logic [15:0] aux_regs_r [8];
    logic        rd_pend_r;

    logic [8:0]  page_pointer;
    logic [2:0]  aux_pointer;
    logic        sign_extend_mode;
    logic [1:0]  product_shift_mode;
    logic [15:0] daddr;
    logic [15:0] next_addr;
    logic [15:0] dword;
    logic [15:0] ram_q;
    logic [15:0] ram_wd;
    logic [9:0]  ram_addr;
    logic        ram_we;
    logic        exec;
    logic        move_ok;
    logic [15:0] sh_in;
    logic [3:0]  shamt;
    logic [31:0] sh_out;
    logic [31:0] psh;
    logic        acc_ph;
    logic        fire_wr;
    logic        is_ram;
    logic [31:0] reg_rd;
    logic        mapped;

    assign page_pointer       = st0_r[8:0];
    assign aux_pointer        = st0_r[lmd_pkg::ST0_ARP_LSB +: 3];
    assign sign_extend_mode   = st1_r[lmd_pkg::ST1_SXM_BIT];
    assign product_shift_mode = st1_r[lmd_pkg::ST1_PM_LSB +: 2];
    assign exec               = state_r == lmd_pkg::ST_EXEC;
    assign psh                = lmd_pkg::pshift(preg_r, product_shift_mode);

    // direct: page concatenated with offset; indirect: current aux reg
    assign daddr     = cmd_r.indirect ? aux_regs_r[aux_pointer]
                                      : {page_pointer, cmd_r.offset};
    assign next_addr = addr_r + 16'h0001;
    // words outside on-chip RAM come from the external data register
    assign dword     = lmd_pkg::is_onchip(region_r) ? ram_q : ext_r;

    // the move needs both source and destination in RAM blocks
    assign move_ok = exec
        && (cmd_r.op == lmd_pkg::OP_LTD || cmd_r.op == lmd_pkg::OP_MUL_ACC_MOVE)
        && lmd_pkg::is_onchip(region_r)
        && lmd_pkg::is_onchip(lmd_pkg::region_of(next_addr));

    assign sh_in = (cmd_r.op == lmd_pkg::OP_LOAD_ACC_LONG_IMM) ? imm_r : dword;
    assign shamt = (cmd_r.op == lmd_pkg::OP_LOAD_ACC_TSHIFT) ? treg_r[3:0]
                                                  : cmd_r.shift;

    lmd_shifter u_shift (
        .value            (sh_in),
        .amount           (shamt),
        .sign_extend_mode (sign_extend_mode),
        .result           (sh_out)
    );

    // apb decode
    assign acc_ph  = psel && penable;
    assign fire_wr = acc_ph && pready && pwrite;
    assign is_ram  = paddr[12] == lmd_pkg::OFF_RAM[12] && paddr[1:0] == 2'h0
                     && paddr[11:2] < 10'h300;

    // single ram port: the sequencer owns it while busy
    always_comb
    begin
        ram_we   = 1'b0;
        ram_addr = paddr[11:2];
        ram_wd   = pwdata[15:0];
        if (state_r == lmd_pkg::ST_FETCH)
            ram_addr = lmd_pkg::ram_index(daddr);
        else if (move_ok)
        begin
            ram_we   = 1'b1;
            ram_addr = lmd_pkg::ram_index(next_addr);
            ram_wd   = dword;
        end
        else if (state_r == lmd_pkg::ST_IDLE && fire_wr && is_ram)
            ram_we = 1'b1;
    end

    lmd_dram #(
        .DW (lmd_pkg::DW),
        .AW (lmd_pkg::RAM_AW)
    ) u_ram (
        .pclk  (pclk),
        .we    (ram_we),
        .addr  (ram_addr),
        .wdata (ram_wd),
        .q     (ram_q)
    );

    always_comb
    begin
        mapped = 1'b1;
        reg_rd = 32'h0000_0000;
        if (paddr[12:5] == lmd_pkg::OFF_AR[12:5] && paddr[1:0] == 2'h0)
            reg_rd = {16'h0000, aux_regs_r[paddr[4:2]]};
        else
        begin
            unique case (paddr)
                lmd_pkg::OFF_CMD:  reg_rd = cmd_r;
                lmd_pkg::OFF_IMM:  reg_rd = {16'h0000, imm_r};
                lmd_pkg::OFF_PROG: reg_rd = {16'h0000, prog_r};
                lmd_pkg::OFF_EXT:  reg_rd = {16'h0000, ext_r};
                lmd_pkg::OFF_ACC:  reg_rd = acc_r;
                lmd_pkg::OFF_PREG: reg_rd = preg_r;
                lmd_pkg::OFF_TREG: reg_rd = {16'h0000, treg_r};
                lmd_pkg::OFF_ST0:  reg_rd = {16'h0000, st0_r};
                lmd_pkg::OFF_ST1:  reg_rd = {16'h0000, st1_r};
                lmd_pkg::OFF_ADDR: reg_rd = {13'h0000, region_r, addr_r};
                default:           mapped = is_ram;
            endcase
        end
    end

    // accesses wait while an instruction runs; ram reads take one more cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            prdata    <= 32'h0000_0000;
            rd_pend_r <= 1'b0;
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            if (acc_ph && !pready && state_r == lmd_pkg::ST_IDLE)
            begin
                if (is_ram && !pwrite && !rd_pend_r)
                    rd_pend_r <= 1'b1;
                else
                begin
                    pready    <= 1'b1;
                    pslverr   <= !mapped;
                    prdata    <= is_ram ? {16'h0000, ram_q} : reg_rd;
                    rd_pend_r <= 1'b0;
                end
            end
        end
    end

    // software-written operand registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            imm_r  <= 16'h0000;
            prog_r <= 16'h0000;
            ext_r  <= 16'h0000;
        end
        else if (fire_wr)
        begin
            if (paddr == lmd_pkg::OFF_IMM)
                imm_r <= pwdata[15:0];
            if (paddr == lmd_pkg::OFF_PROG)
                prog_r <= pwdata[15:0];
            if (paddr == lmd_pkg::OFF_EXT)
                ext_r <= pwdata[15:0];
        end
    end

    // sequencer: a command write launches fetch then execute
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r  <= lmd_pkg::ST_IDLE;
            cmd_r    <= '0;
            addr_r   <= 16'h0000;
            region_r <= lmd_pkg::RG_EXT;
        end
        else
        begin
            unique case (state_r)
                lmd_pkg::ST_IDLE:
                    if (fire_wr && paddr == lmd_pkg::OFF_CMD)
                    begin
                        cmd_r   <= pwdata;
                        state_r <= lmd_pkg::ST_FETCH;
                    end
                lmd_pkg::ST_FETCH:
                begin
                    addr_r   <= daddr;
                    region_r <= lmd_pkg::region_of(daddr);
                    state_r  <= lmd_pkg::ST_EXEC;
                end
                lmd_pkg::ST_EXEC:
                    state_r <= lmd_pkg::ST_IDLE;
                default:
                    state_r <= lmd_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            acc_r <= 32'h0000_0000;
        else if (exec)
        begin
            unique case (cmd_r.op)
                lmd_pkg::OP_LOAD_ACC_TSHIFT,
                lmd_pkg::OP_LOAD_ACC_LONG_IMM: acc_r <= sh_out;
                lmd_pkg::OP_LTA,
                lmd_pkg::OP_LTD,
                lmd_pkg::OP_MAC,
                lmd_pkg::OP_MUL_ACC_MOVE: acc_r <= acc_r + psh;
                lmd_pkg::OP_LTP:  acc_r <= preg_r;
                lmd_pkg::OP_LTS:  acc_r <= acc_r - psh;
                default:          acc_r <= acc_r;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            preg_r <= 32'h0000_0000;
        else if (exec && cmd_r.op == lmd_pkg::OP_LPH)
            preg_r[31:16] <= dword;
        else if (exec && (cmd_r.op == lmd_pkg::OP_MAC
                          || cmd_r.op == lmd_pkg::OP_MUL_ACC_MOVE))
            // widen both operands first so the product keeps all 32 bits
            preg_r <= 32'($signed(dword)) * 32'($signed(prog_r));
    end

    // every multiplicand load takes the addressed word
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            treg_r <= 16'h0000;
        else if (exec)
        begin
            unique case (cmd_r.op)
                lmd_pkg::OP_LT, lmd_pkg::OP_LTA, lmd_pkg::OP_LTD,
                lmd_pkg::OP_LTP, lmd_pkg::OP_LTS, lmd_pkg::OP_MAC,
                lmd_pkg::OP_MUL_ACC_MOVE: treg_r <= dword;
                default:          treg_r <= treg_r;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 8; i++)
                aux_regs_r[i] <= 16'h0000;
        end
        else if (exec)
        begin
            unique case (cmd_r.op)
                lmd_pkg::OP_LAR_DATA:
                    aux_regs_r[cmd_r.sel] <= dword;
                lmd_pkg::OP_LAR_SHORT:
                    aux_regs_r[cmd_r.sel] <= {8'h00, imm_r[7:0]};
                lmd_pkg::OP_LAR_LONG:
                    aux_regs_r[cmd_r.sel] <= imm_r;
                default:
                    aux_regs_r[cmd_r.sel] <= aux_regs_r[cmd_r.sel];
            endcase
        end
    end

    // status word zero also holds the aux pointer and the page pointer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st0_r <= lmd_pkg::ST0_RST;
        else if (exec)
        begin
            unique case (cmd_r.op)
                lmd_pkg::OP_LST0: st0_r <= dword;
                lmd_pkg::OP_LSTN:
                    if (!cmd_r.sel[0])
                        st0_r <= dword;
                lmd_pkg::OP_LOAD_AUX_POINTER:
                    st0_r[lmd_pkg::ST0_ARP_LSB +: 3] <= cmd_r.sel;
                lmd_pkg::OP_MAR:
                    if (!cmd_r.indirect)
                        st0_r[lmd_pkg::ST0_ARP_LSB +: 3] <= cmd_r.sel;
                lmd_pkg::OP_LDP:  st0_r[8:0] <= dword[8:0];
                lmd_pkg::OP_LOAD_PAGE_SHORT: st0_r[8:0] <= imm_r[8:0];
                default:          st0_r <= st0_r;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st1_r <= lmd_pkg::ST1_RST;
        else if (exec && (cmd_r.op == lmd_pkg::OP_LOAD_STATUS_ONE
                          || (cmd_r.op == lmd_pkg::OP_LSTN && cmd_r.sel[0])))
            st1_r <= dword;
    end

    // independent reference of the widened load operand
    logic [31:0] chk_ext;
    assign chk_ext = sign_extend_mode ? {{16{sh_in[15]}}, sh_in}
                                      : {16'h0000, sh_in};

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_load_acc_tshift_shift;
        exec && cmd_r.op == lmd_pkg::OP_LOAD_ACC_TSHIFT
            |=> acc_r == ($past(chk_ext) << $past(treg_r[3:0]));
    endproperty
    a_load_acc_tshift_shift: assert property (p_load_acc_tshift_shift)
        else $error("shift-by-multiplicand load wrong");

    property p_zero_fill;
        exec && (cmd_r.op == lmd_pkg::OP_LOAD_ACC_TSHIFT || cmd_r.op == lmd_pkg::OP_LOAD_ACC_LONG_IMM)
            |=> (acc_r & ~(32'hffff_ffff << $past(shamt))) == 32'h0000_0000;
    endproperty
    a_zero_fill: assert property (p_zero_fill)
        else $error("low bits not zero filled");

    property p_no_sext;
        exec && !sign_extend_mode && (cmd_r.op == lmd_pkg::OP_LOAD_ACC_TSHIFT
                                      || cmd_r.op == lmd_pkg::OP_LOAD_ACC_LONG_IMM)
            |=> (acc_r >> (5'd16 + 5'($past(shamt)))) == 32'h0000_0000;
    endproperty
    a_no_sext: assert property (p_no_sext)
        else $error("high bits not zero without sign extension");

    property p_load_acc_long_imm;
        exec && cmd_r.op == lmd_pkg::OP_LOAD_ACC_LONG_IMM
            |=> acc_r[15:0] == 16'($past(imm_r) << $past(cmd_r.shift));
    endproperty
    a_load_acc_long_imm: assert property (p_load_acc_long_imm)
        else $error("long immediate load wrong");

    property p_load_aux_short;
        exec && cmd_r.op == lmd_pkg::OP_LAR_SHORT
            |=> aux_regs_r[$past(cmd_r.sel)] == {8'h00, $past(imm_r[7:0])};
    endproperty
    a_load_aux_short: assert property (p_load_aux_short)
        else $error("short aux load not positive 8-bit");

    property p_load_aux_pointer;
        exec && cmd_r.op == lmd_pkg::OP_LOAD_AUX_POINTER |=> aux_pointer == $past(cmd_r.sel);
    endproperty
    a_load_aux_pointer: assert property (p_load_aux_pointer)
        else $error("aux pointer not loaded");

    sequence s_load_page_short_run;
        fire_wr && paddr == lmd_pkg::OFF_CMD
            && pwdata[4:0] == lmd_pkg::OP_LOAD_PAGE_SHORT
            ##1 state_r == lmd_pkg::ST_FETCH ##1 exec;
    endsequence
    property p_load_page_short;
        s_load_page_short_run |=> page_pointer == $past(imm_r[8:0], 1);
    endproperty
    a_load_page_short: assert property (p_load_page_short)
        else $error("page pointer not loaded from immediate");

    property p_region;
        exec && addr_r[15:7] >= lmd_pkg::PAGE_EXT_MIN |-> region_r == lmd_pkg::RG_EXT;
    endproperty
    a_region: assert property (p_region)
        else $error("high page not external");

    property p_lph;
        exec && cmd_r.op == lmd_pkg::OP_LPH
            |=> preg_r[15:0] == $past(preg_r[15:0])
                && preg_r[31:16] == $past(dword);
    endproperty
    a_lph: assert property (p_lph)
        else $error("high product load disturbed low half");

    property p_no_move;
        exec && !lmd_pkg::is_onchip(region_r) |-> !ram_we;
    endproperty
    a_no_move: assert property (p_no_move)
        else $error("data move outside on-chip RAM");
endmodule

// File: lmd_apb_host.sv
`timescale 1ns/100ps
module lmd_apb_host (
    // bus
    input  wire logic        pclk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [12:0] paddr,
    output logic      [31:0] pwdata
);
    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 13'h0000;
        pwdata  = 32'h0000_0000;
    end
    // entered just after a rising edge; the idle cycle at the end keeps
    // two requests from being driven in one time step
    task automatic xfer(input logic w, input logic [12:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
endmodule

// File: tb_load_and_mac_datapath.sv
`timescale 1ns/100ps
module tb_load_and_mac_datapath;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [12:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    int          fail_count;
    int          checked;
    int          cycles;
    localparam logic [8:0] PG [3] = '{9'h000, 9'h007, 9'h008};
    localparam logic [6:0] OF [3] = '{7'h60, 7'h01, 7'h01};
    localparam logic [2:0] RG [3] = '{3'h4, 3'h3, 3'h0};
    lmd_datapath dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    lmd_apb_host host (.pclk(pclk), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));
    always #50 pclk = ~pclk;
    task automatic close_out();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // a few hundred cycles are needed; the ceiling leaves ample margin
    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            fail_count = fail_count + 1;
            close_out();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked = checked + 1;
        if (got !== exp)
        begin
            fail_count = fail_count + 1;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [12:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        host.xfer(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [12:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic        e;
        host.xfer(1'b0, a, 32'h0000_0000, q, e);
        check(q, x);
    endtask
    task automatic run(input lmd_pkg::lmd_op_t o, input logic [2:0] s,
                       input logic [3:0] h, input logic [6:0] f,
                       input logic i);
        wr(lmd_pkg::OFF_CMD, {12'h000, f, h, s, i, o});
    endtask
    // direct access at offset 1: page 0 and page 8 both read the EXT word
    task automatic ex(input lmd_pkg::lmd_op_t o, input logic [2:0] s);
        run(o, s, 4'h0, 7'h01, 1'b0);
    endtask
    task automatic t_shift();
        rd(lmd_pkg::OFF_ST1, {16'h0000, lmd_pkg::ST1_RST});
        wr(lmd_pkg::OFF_EXT, 32'h0000_0004);
        ex(lmd_pkg::OP_LT, 3'h0);
        wr(lmd_pkg::OFF_EXT, 32'h0000_8421);
        ex(lmd_pkg::OP_LOAD_ACC_TSHIFT, 3'h0);
        rd(lmd_pkg::OFF_ACC, 32'hfff8_4210);
        wr(lmd_pkg::OFF_EXT, 32'h0000_0001);
        ex(lmd_pkg::OP_LOAD_STATUS_ONE, 3'h0);
        rd(lmd_pkg::OFF_ST1, 32'h0000_0001);
        wr(lmd_pkg::OFF_EXT, 32'h0000_8421);
        ex(lmd_pkg::OP_LOAD_ACC_TSHIFT, 3'h0);
        rd(lmd_pkg::OFF_ACC, 32'h0008_4210);
        wr(lmd_pkg::OFF_IMM, 32'h0000_8000);
        run(lmd_pkg::OP_LOAD_ACC_LONG_IMM, 3'h0, 4'h3, 7'h01, 1'b0);
        rd(lmd_pkg::OFF_ACC, 32'h0004_0000);
    endtask
    task automatic t_aux();
        wr(lmd_pkg::OFF_IMM, 32'h0000_ffab);
        ex(lmd_pkg::OP_LAR_SHORT, 3'h3);
        rd(lmd_pkg::OFF_AR + 13'h00c, 32'h0000_00ab);
        ex(lmd_pkg::OP_LAR_LONG, 3'h5);
        rd(lmd_pkg::OFF_AR + 13'h014, 32'h0000_ffab);
        wr(lmd_pkg::OFF_EXT, 32'h0000_e000);
        ex(lmd_pkg::OP_LAR_DATA, 3'h1);
        rd(lmd_pkg::OFF_AR + 13'h004, 32'h0000_e000);
        ex(lmd_pkg::OP_LSTN, 3'h0);
        rd(lmd_pkg::OFF_ST0, 32'h0000_e000);
        ex(lmd_pkg::OP_LOAD_AUX_POINTER, 3'h6);
        rd(lmd_pkg::OFF_ST0, 32'h0000_c000);
        run(lmd_pkg::OP_MAR, 3'h2, 4'h0, 7'h01, 1'b1);
        rd(lmd_pkg::OFF_ST0, 32'h0000_c000);
        ex(lmd_pkg::OP_MAR, 3'h2);
        rd(lmd_pkg::OFF_ST0, 32'h0000_4000);
    endtask
    task automatic t_page();
        wr(lmd_pkg::OFF_EXT, 32'h0000_fe04);
        ex(lmd_pkg::OP_LDP, 3'h0);
        rd(lmd_pkg::OFF_ST0, 32'h0000_4004);
        wr(lmd_pkg::OFF_RAM + 13'h0014, 32'h0000_1234);
        run(lmd_pkg::OP_LTD, 3'h0, 4'h0, 7'h05, 1'b0);
        rd(lmd_pkg::OFF_TREG, 32'h0000_1234);
        rd(lmd_pkg::OFF_ADDR, 32'h0002_0205);
        rd(lmd_pkg::OFF_RAM + 13'h0018, 32'h0000_1234);
        wr(lmd_pkg::OFF_RAM + 13'h0024, 32'h0000_0003);
        wr(lmd_pkg::OFF_PROG, 32'h0000_0005);
        run(lmd_pkg::OP_MUL_ACC_MOVE, 3'h0, 4'h0, 7'h09, 1'b0);
        rd(lmd_pkg::OFF_RAM + 13'h0028, 32'h0000_0003);
        for (int i = 0; i < 3; i++)
        begin
            wr(lmd_pkg::OFF_IMM, {23'h000000, PG[i]});
            ex(lmd_pkg::OP_LOAD_PAGE_SHORT, 3'h0);
            run(lmd_pkg::OP_LT, 3'h0, 4'h0, OF[i], 1'b0);
            rd(lmd_pkg::OFF_ADDR, {13'h0000, RG[i], PG[i], OF[i]});
        end
    endtask
    task automatic t_mac();
        logic [31:0] q;
        logic        e;
        wr(lmd_pkg::OFF_EXT, 32'h0000_fffe);
        ex(lmd_pkg::OP_MAC, 3'h0);
        rd(lmd_pkg::OFF_ACC, 32'h0004_001e);
        rd(lmd_pkg::OFF_PREG, 32'hffff_fff6);
        wr(lmd_pkg::OFF_EXT, 32'h0000_1234);
        ex(lmd_pkg::OP_LPH, 3'h0);
        rd(lmd_pkg::OFF_PREG, 32'h1234_fff6);
        ex(lmd_pkg::OP_LTP, 3'h0);
        rd(lmd_pkg::OFF_ACC, 32'h1234_fff6);
        ex(lmd_pkg::OP_LTA, 3'h0);
        rd(lmd_pkg::OFF_ACC, 32'h1234_fff6 + 32'h2469_ffec);
        ex(lmd_pkg::OP_LTS, 3'h0);
        rd(lmd_pkg::OFF_ACC, 32'h1234_fff6);
        host.xfer(1'b0, 13'h0030, 32'h0000_0000, q, e);
        check({q[30:0], e}, 32'h0000_0001);
        wr(lmd_pkg::OFF_ACC, 32'h0000_0000);
        rd(lmd_pkg::OFF_ACC, 32'h1234_fff6);
    endtask
    initial
    begin
        pclk       = 1'b0;
        presetn    = 1'b0;
        fail_count = 0;
        checked    = 0;
        cycles     = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_shift();
        t_aux();
        t_page();
        t_mac();
        close_out();
    end
endmodule
